// ===== core/adcrc_pkg.sv
/*
  constants, field layout and timing figures shared by both ends of the
  converter mode-control link.
  assumes a single 50 MHz clock shared by both ends.
*/
package adcrc_pkg;
  // ----------------------------------------------------------------
  // link and register layout
  // ----------------------------------------------------------------
  localparam int DW = 24;
  localparam int AW = 2;
  localparam logic [AW-1:0] ADDR_MODE   = 2'h0;
  localparam logic [AW-1:0] ADDR_PHASE  = 2'h1;
  localparam logic [AW-1:0] ADDR_DATA   = 2'h2;
  localparam logic [AW-1:0] ADDR_STATUS = 2'h3;
  // mode_control_register fields
  localparam int MODE_W      = 5;
  localparam int BIT_SOFTRST = 0;
  localparam int BIT_SHDN_LO = 1;
  localparam int BIT_SHDN_HI = 2;
  localparam int BIT_EXTREF  = 3;
  localparam int BIT_EXTCLK  = 4;
  localparam logic [MODE_W-1:0] MODE_RST   = 5'h00;
  localparam logic [MODE_W-1:0] MODE_LOCKD = 5'h07;
  localparam logic [7:0]        PHASE_RST  = 8'h00;
  localparam logic [3:0]        COMP_RST   = 4'h3;
  localparam logic [3:0]        COMP_RUN   = 4'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [7:0] DEC_LAST    = 8'hFF;
  localparam logic [2:0] SETTLE_CONV = 3'h3;
  localparam int BIAS_SETTLE_NS  = 1000000;
  localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC      = 4 * 256;
  localparam int DISCARD_CYC     = BIAS_SETTLE_CYC + SETTLE_CYC;
  localparam int DISC_W          = 17;
  // host-side software port
  localparam int HAW = 2;
  localparam int HDW = 32;
  localparam logic [HAW-1:0] HADDR_CTRL   = 2'h0;
  localparam logic [HAW-1:0] HADDR_WRITE  = 2'h1;
  localparam logic [HAW-1:0] HADDR_READ   = 2'h2;
  localparam logic [HAW-1:0] HADDR_SAMPLE = 2'h3;
  localparam int HBIT_HOLDRST = 0;
  localparam int HBIT_WDOG    = 1;
  localparam int HADDR_LO     = 24;
endpackage

// ===== core/adcrc_link_if.sv
/*
  link between the host controller and the converter's mode logic.
  assumes both ends run on the same clock; the pins resetPinN, wdogReset
  are resynchronised by the converter.
*/
`timescale 1ns/1ns
interface adcrc_link_if;
  import adcrc_pkg::*;
  logic          resetPinN;
  logic          wdogReset;
  logic          wrStb;
  logic          rdStb;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdData;
  logic          ifaceReady;
  logic          dataReady;
  logic [DW-1:0] dataOut;
  logic          twoWire;

  modport dev (
    input  resetPinN, wdogReset, wrStb, rdStb, addr, wdata,
    output rdData, ifaceReady, dataReady, dataOut, twoWire
  );
  modport host (
    output resetPinN, wdogReset, wrStb, rdStb, addr, wdata,
    input  rdData, ifaceReady, dataReady, dataOut, twoWire
  );
endinterface

// ===== core/adcrc_device.sv
/*
  converter end: mode control register, soft reset, hard reset, converter
  shutdown and full shutdown, with a small decimation model.
  assumes rawSample is a modulator word on clk; resetPinN and the strap
  come from pins and are resynchronised here.
*/
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module adcrc_device
  import adcrc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          twoWireStrap,
  input  wire logic [DW-1:0] rawSample,
  adcrc_link_if.dev          link,
  output logic               inputClkEn,
  output logic               coreClkEn,
  output logic               biasEn,
  output logic               vrefEn,
  output logic               porMonEn,
  output logic               fullShutdown,
  output logic [3:0]         compOut
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        pinSync;
    logic [1:0]        wdSync;
    logic [1:0]        strapSync;
    logic              strapDone;
    logic [1:0]        strapWait;
    logic              twoWire;
    logic [MODE_W-1:0] mode;
    logic [7:0]        phase;
    logic [DW-1:0]     data;
    logic [DW-1:0]     acc;
    logic [DW-1:0]     outBuf;
    logic [7:0]        decCnt;
    logic [2:0]        settleCnt;
    logic              wasIdle;
    logic [DW-1:0]     rdData;
    logic              ifaceReady;
    logic              dataReady;
    logic              inputClkEn;
    logic              coreClkEn;
    logic              biasEn;
    logic              vrefEn;
    logic              porMonEn;
    logic              fullShutdown;
    logic [3:0]        comp;
  } adcrc_dev_t;

  localparam adcrc_dev_t DEV_RST = '{
    pinSync: 2'h0, wdSync: 2'h0, strapSync: 2'h0, strapDone: 1'b0, strapWait: 2'h0,
    twoWire: 1'b0, mode: MODE_RST, phase: PHASE_RST, data: '0, acc: '0,
    outBuf: '0, decCnt: PHASE_RST, settleCnt: SETTLE_CONV, wasIdle: 1'b0,
    rdData: '0, ifaceReady: 1'b0, dataReady: 1'b0, inputClkEn: 1'b1,
    coreClkEn: 1'b1, biasEn: 1'b1, vrefEn: 1'b1, porMonEn: 1'b1,
    fullShutdown: 1'b0, comp: COMP_RST
  };

  adcrc_dev_t st;
  adcrc_dev_t next_st;

  logic              hardRst;
  logic              softRst;
  logic              shut;
  logic              full;
  logic [MODE_W-1:0] wrMode;
  logic [7:0]        status;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // only the second stage of each synchroniser is looked at
    next_st.pinSync   = {st.pinSync[0], link.resetPinN};
    next_st.wdSync    = {st.wdSync[0], link.wdogReset};
    next_st.strapSync = {st.strapSync[0], twoWireStrap};

    // strap not yet settled: stay in reset so the pin is judged correctly
    hardRst = !st.strapDone
            || (!st.twoWire && !st.pinSync[1])
            || (st.twoWire && st.wdSync[1]);

    softRst = st.mode[BIT_SOFTRST];
    shut    = st.mode[BIT_SHDN_LO] || st.mode[BIT_SHDN_HI];
    full    = st.mode[BIT_SHDN_LO] && st.mode[BIT_EXTREF] && st.mode[BIT_EXTCLK];

    // mode bits refused in two-wire mode: soft reset, shutdown, and so
    // full shutdown, stay as they were
    wrMode = link.wdata[MODE_W-1:0];
    if (st.twoWire) begin
      wrMode[BIT_SOFTRST] = st.mode[BIT_SOFTRST];
      wrMode[BIT_SHDN_LO] = st.mode[BIT_SHDN_LO];
      wrMode[BIT_SHDN_HI] = st.mode[BIT_SHDN_HI];
    end

    status = {1'b0, st.twoWire, full, shut, softRst,
              (st.settleCnt == 3'h0), st.porMonEn, st.ifaceReady};

    next_st.dataReady = 1'b0;
    next_st.rdData    = '0;

    // register port; the serial side stays alive in every shutdown
    if (st.ifaceReady && link.wrStb) begin
      unique case (link.addr)
        ADDR_MODE: begin
          next_st.mode = wrMode;
          if (wrMode[BIT_SOFTRST] && !softRst) begin
            next_st.data = '0;
          end
        end
        ADDR_PHASE: next_st.phase = link.wdata[7:0];
        default: ;
      endcase
    end
    if (st.ifaceReady && link.rdStb) begin
      unique case (link.addr)
        ADDR_MODE:   next_st.rdData = {{(DW-MODE_W){1'b0}}, st.mode};
        ADDR_PHASE:  next_st.rdData = {16'h0000, st.phase};
        ADDR_DATA:   next_st.rdData = st.data;
        ADDR_STATUS: next_st.rdData = {16'h0000, status};
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // converter model
    // ----------------------------------------------------------------
    next_st.comp = COMP_RUN;
    if (shut) begin
      // clocks gated: filter frozen, output flushed
      next_st.data    = '0;
      next_st.wasIdle = 1'b1;
    end else if (st.wasIdle && !softRst) begin
      // restart on the kept phase so the delay still applies
      next_st.wasIdle   = softRst;
      next_st.decCnt    = st.phase;
      next_st.settleCnt = SETTLE_CONV;
    end else begin
      // running, also in soft reset: the filter keeps integrating
      next_st.acc    = st.acc + rawSample;
      next_st.decCnt = st.decCnt + 8'h01;
      if (softRst) begin
        next_st.wasIdle = 1'b1;
        next_st.data    = '0;
      end
      if (st.decCnt == DEC_LAST) begin
        next_st.acc    = rawSample;
        next_st.outBuf = st.acc;
        if (st.settleCnt != 3'h0) begin
          next_st.settleCnt = st.settleCnt - 3'h1;
        end else if (!softRst) begin
          next_st.data      = st.outBuf;
          next_st.dataReady = 1'b1;
        end
      end
    end
    if (softRst && !shut) begin
      next_st.wasIdle = 1'b1;
    end

    // power and clock controls
    next_st.inputClkEn   = !shut;
    next_st.coreClkEn    = !shut;
    next_st.biasEn       = !shut;
    next_st.vrefEn       = !full;
    next_st.fullShutdown = full;
    next_st.porMonEn     = !full;
    next_st.ifaceReady   = 1'b1;

    if (hardRst) begin
      next_st            = DEV_RST;
      next_st.pinSync    = {st.pinSync[0], link.resetPinN};
      next_st.wdSync     = {st.wdSync[0], link.wdogReset};
      next_st.strapSync  = {st.strapSync[0], twoWireStrap};
      next_st.strapDone  = st.strapDone;
      next_st.strapWait  = st.strapWait;
      next_st.twoWire    = st.twoWire;
      next_st.comp       = COMP_RST;
      next_st.ifaceReady = 1'b0;
    end

    // strap judged once, only after its synchroniser has filled
    if (!st.strapDone) begin
      if (st.strapWait == 2'h2) begin
        next_st.twoWire   = st.strapSync[1];
        next_st.strapDone = 1'b1;
      end else begin
        next_st.strapWait = st.strapWait + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= DEV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.rdData     = st.rdData;
  assign link.ifaceReady = st.ifaceReady;
  assign link.dataReady  = st.dataReady;
  assign link.dataOut    = st.data;
  assign link.twoWire    = st.twoWire;
  assign inputClkEn      = st.inputClkEn;
  assign coreClkEn       = st.coreClkEn;
  assign biasEn          = st.biasEn;
  assign vrefEn          = st.vrefEn;
  assign porMonEn        = st.porMonEn;
  assign fullShutdown    = st.fullShutdown;
  assign compOut         = st.comp;
endmodule

// ===== core/adcrc_host.sv
/*
  host end: turns software register accesses into link transfers,
  drives the reset pin or the watchdog request, and drops early results
  after a converter shutdown.
  assumes the converter end shares clk.
*/
`timescale 1ns/1ns
module adcrc_host
  import adcrc_pkg::*;
#(
  parameter int DISCARD = DISCARD_CYC
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic [HAW-1:0] swAddr,
  input  wire logic [HDW-1:0] swWdata,
  input  wire logic           swWr,
  input  wire logic           swRd,
  output logic      [HDW-1:0] swRdata,
  adcrc_link_if.host          link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              holdRst;
    logic              wdog;
    logic              wr;
    logic              rd;
    logic [AW-1:0]     addr;
    logic [DW-1:0]     wdata;
    logic              rdPend;
    logic [DW-1:0]     rdCap;
    logic [DW-1:0]     sample;
    logic              fresh;
    logic [MODE_W-1:0] shadow;
    logic [DISC_W-1:0] discCnt;
    logic [HDW-1:0]    swRdata;
  } adcrc_host_t;

  localparam adcrc_host_t HOST_RST = '{
    holdRst: 1'b0, wdog: 1'b0, wr: 1'b0, rd: 1'b0, addr: '0, wdata: '0,
    rdPend: 1'b0, rdCap: '0, sample: '0, fresh: 1'b0, shadow: MODE_RST,
    discCnt: '0, swRdata: '0
  };

  adcrc_host_t st;
  adcrc_host_t next_st;

  logic              linkOk;
  logic [MODE_W-1:0] newMode;

  always_comb begin
    next_st         = st;
    next_st.wr      = 1'b0;
    next_st.rd      = 1'b0;
    next_st.wdog    = 1'b0;
    next_st.rdPend  = 1'b0;
    next_st.swRdata = '0;
    // transfers are refused while the converter holds its port in reset
    linkOk  = link.ifaceReady && !st.holdRst && !st.wdog
           && !st.wr && !st.rd;
    newMode = swWdata[MODE_W-1:0];
    if (link.twoWire) begin
      newMode = {swWdata[BIT_EXTCLK], swWdata[BIT_EXTREF],
                 st.shadow[BIT_SHDN_HI:BIT_SOFTRST]};
    end

    if (st.rdPend) begin
      next_st.rdCap = link.rdData;
    end
    if (st.discCnt != '0) begin
      next_st.discCnt = st.discCnt - 1'b1;
    end
    // a result inside the discard window (bias plus filter settling) is dropped
    if (link.dataReady && st.discCnt == '0) begin
      next_st.sample = link.dataOut;
      next_st.fresh  = 1'b1;
    end

    if (swWr) begin
      unique case (swAddr)
        HADDR_CTRL: begin
          // the pin only acts in SPI mode; two-wire needs the watchdog
          next_st.holdRst = swWdata[HBIT_HOLDRST] && !link.twoWire;
          next_st.wdog    = swWdata[HBIT_WDOG] && link.twoWire;
          if (next_st.holdRst || next_st.wdog) begin
            next_st.shadow = MODE_RST;
          end
        end
        HADDR_WRITE: begin
          if (linkOk) begin
            next_st.wr    = 1'b1;
            next_st.addr  = swWdata[HADDR_LO +: AW];
            next_st.wdata = swWdata[DW-1:0];
            if (swWdata[HADDR_LO +: AW] == ADDR_MODE) begin
              next_st.wdata  = {{(DW-MODE_W){1'b0}}, newMode};
              next_st.shadow = newMode;
              if ((st.shadow[BIT_SHDN_HI:BIT_SHDN_LO] != 2'h0)
                  && (newMode[BIT_SHDN_HI:BIT_SHDN_LO] == 2'h0)) begin
                next_st.discCnt = DISC_W'(DISCARD);
              end
            end
          end
        end
        HADDR_READ: begin
          if (linkOk) begin
            next_st.rd   = 1'b1;
            next_st.addr = swWdata[AW-1:0];
          end
        end
        default: ;
      endcase
    end

    if (st.rd) begin
      next_st.rdPend = 1'b1;
    end

    if (swRd) begin
      unique case (swAddr)
        HADDR_CTRL: next_st.swRdata = {27'h0, st.discCnt != '0, st.fresh,
                                       link.twoWire, link.ifaceReady, st.holdRst};
        HADDR_READ: next_st.swRdata = {8'h00, st.rdCap};
        HADDR_SAMPLE: begin
          next_st.swRdata = {8'h00, st.sample};
          // a new result in the same cycle keeps the flag set
          if (!(link.dataReady && st.discCnt == '0)) begin
            next_st.fresh = 1'b0;
          end
        end
        default: next_st.swRdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= HOST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.resetPinN = !st.holdRst;
  assign link.wdogReset = st.wdog;
  assign link.wrStb     = st.wr;
  assign link.rdStb     = st.rd;
  assign link.addr      = st.addr;
  assign link.wdata     = st.wdata;
  assign swRdata        = st.swRdata;
endmodule

// ===== dv/adcrc_link_chk.sv
/*
  concurrent checks on the link between host end and converter end.
  assumes it watches the one link instance that joins both design ends.
*/
`timescale 1ns/1ns
module adcrc_link_chk
  import adcrc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          resetPinN,
  input wire logic          wdogReset,
  input wire logic          wrStb,
  input wire logic          rdStb,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] rdData,
  input wire logic          ifaceReady,
  input wire logic          dataReady,
  input wire logic [DW-1:0] dataOut,
  input wire logic          twoWire
);
  // ----------------------------------------------------------------
  // shadow of the mode and phase registers, settling counter
  // ----------------------------------------------------------------
  logic [MODE_W-1:0] mode;
  logic [7:0]        phase;
  logic [10:0]       cnt;
  logic              seen;
  logic [5:0]        wdHist;
  wire               held = mode[2:0] != 3'h0;

  // saturated count after a hard reset: the filter restart point is unknown there
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn || !ifaceReady) begin
      mode  <= MODE_RST;
      phase <= PHASE_RST;
      cnt   <= 11'h7FF;
      seen  <= 1'b1;
    end else begin
      if (wrStb && addr == ADDR_MODE)
        mode <= twoWire ? {wdata[4:3], mode[2:0]} : wdata[MODE_W-1:0];
      if (wrStb && addr == ADDR_PHASE)
        phase <= wdata[7:0];
      cnt  <= held ? 11'h000 : (cnt == 11'h7FF) ? cnt : cnt + 11'h001;
      seen <= held ? 1'b0 : (seen | dataReady);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      wdHist <= 6'h00;
    else
      wdHist <= {wdHist[4:0], wdogReset};
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_NO_XFER_IN_HARD: assert property ((wrStb || rdStb) |-> ifaceReady)
    else $error("link strobe while interface held in reset");
  AST_PIN_RESETS: assert property ($fell(resetPinN) && !twoWire |-> ##[1:5] !ifaceReady)
    else $error("reset pin did not reset the interface");
  AST_WDOG_RESETS: assert property (wdogReset && twoWire |-> ##[1:5] !ifaceReady)
    else $error("watchdog request did not reset the interface");
  AST_TWO_WIRE_PIN_IGNORED: assert property (twoWire && ifaceReady && wdHist == 6'h00 && !wdogReset |=> ifaceReady)
    else $error("interface reset in two-wire mode without watchdog");
  AST_NO_READY_HELD: assert property (held |=> !dataReady)
    else $error("data ready pulse in soft reset or shutdown");
  AST_ZERO_OUT_HELD: assert property (held && $past(held) |-> dataOut == '0)
    else $error("output data not zero in soft reset or shutdown");
  AST_PHASE_KEPT: assert property (rdStb && addr == ADDR_PHASE |=> rdData[7:0] == phase)
    else $error("phase readback differs from last written value");
  AST_MODE_READ: assert property (rdStb && addr == ADDR_MODE |=> rdData[MODE_W-1:0] == mode)
    else $error("mode readback differs from last accepted value");
  AST_NO_EARLY_READY: assert property (dataReady |-> cnt > 11'h2F8)
    else $error("data ready before filter settling time");
  AST_READY_AFTER_SETTLE: assert property (cnt == 11'h410 |-> seen)
    else $error("no data ready after filter settling time");
  AST_HARD_CLEARS: assert property (!ifaceReady |=> dataOut == '0 && !dataReady)
    else $error("data not cleared during hard reset");

  COV_READY: cover property (dataReady);
  COV_EXIT_HELD: cover property ($fell(held));
  COV_WDOG: cover property (wdogReset && twoWire);
endmodule

// ===== dv/tb_adc_reset_shutdown_control.sv
/*
  testbench: host end and converter end joined by one link, driven
  through the host software port.
  assumes the host is built with a short discard window.
*/
`timescale 1ns/1ns
module tb_adc_reset_shutdown_control;
  import adcrc_pkg::*;
  logic           clk;
  logic           rstn;
  logic           strap;
  logic [DW-1:0]  raw;
  logic [HAW-1:0] swAddr;
  logic [HDW-1:0] swWdata;
  logic           swWr;
  logic           swRd;
  logic [HDW-1:0] swRdata;
  logic           inClk;
  logic           coreClk;
  logic           bias;
  logic           vref;
  logic           porMon;
  logic           full;
  logic [3:0]     comp;
  logic [HDW-1:0] v;
  int             err_total;
  int             total_checks;
  int             rdyCnt;
  int             cyc;
  int             t0;
  int             bits [3] = '{1, 3, 4};

  // ----------------------------------------------------------------
  // ends, link and checker
  // ----------------------------------------------------------------
  adcrc_link_if link ();
  adcrc_device adcrc_device_inst (.clk(clk), .rstn(rstn), .twoWireStrap(strap),
    .rawSample(raw), .link(link), .inputClkEn(inClk), .coreClkEn(coreClk),
    .biasEn(bias), .vrefEn(vref), .porMonEn(porMon), .fullShutdown(full), .compOut(comp));
  adcrc_host #(.DISCARD(50)) adcrc_host_inst (.clk(clk), .rstn(rstn), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .link(link));
  adcrc_link_chk adcrc_link_chk_inst (.clk(clk), .rstn(rstn), .resetPinN(link.resetPinN),
    .wdogReset(link.wdogReset), .wrStb(link.wrStb), .rdStb(link.rdStb), .addr(link.addr),
    .wdata(link.wdata), .rdData(link.rdData), .ifaceReady(link.ifaceReady),
    .dataReady(link.dataReady), .dataOut(link.dataOut), .twoWire(link.twoWire));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (link.dataReady === 1'b1) rdyCnt <= rdyCnt + 1;

  // ----------------------------------------------------------------
  // access and report tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timeout(input string nm);
    err_total++;
    $display("[FAIL] %s expected event seen timeout", nm);
    conclude();
  endtask
  task automatic chk(input string nm, input logic [HDW-1:0] e, input logic [HDW-1:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sw_wr(input logic [HAW-1:0] a, input logic [HDW-1:0] d);
    @(posedge clk);
    swAddr  <= a;
    swWdata <= d;
    swWr    <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
  endtask
  task automatic sw_rd(input logic [HAW-1:0] a, output logic [HDW-1:0] d);
    @(posedge clk);
    swAddr <= a;
    swRd   <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    #1 d = swRdata;
  endtask
  task automatic link_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    sw_wr(HADDR_WRITE, {6'h00, a, d});
    repeat (3) @(posedge clk);
  endtask
  task automatic link_rd(input logic [AW-1:0] a, output logic [HDW-1:0] d);
    sw_wr(HADDR_READ, {30'h0, a});
    repeat (3) @(posedge clk);
    sw_rd(HADDR_READ, d);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      sw_rd(HADDR_CTRL, v);
      if (v[1] === 1'b1) return;
    end
    timeout("ifaceReady");
  endtask
  task automatic wait_pulse(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (link.dataReady === 1'b1) return;
    end
    timeout("dataReady");
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    strap = 1'b0;
    raw = 24'h000010;
    swAddr = '0;
    swWdata = '0;
    swWr = 1'b0;
    swRd = 1'b0;
    err_total = 0;
    total_checks = 0;
    rdyCnt = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait_ready();
    link_rd(ADDR_MODE, v);
    chk("mode", MODE_RST, v);
    link_rd(ADDR_PHASE, v);
    chk("phase", PHASE_RST, v);
    chk("compOut", COMP_RUN, comp);
    $display("test defaults done");
    link_wr(ADDR_PHASE, 24'h000040);
    link_wr(ADDR_MODE, 24'h000001);
    t0 = rdyCnt;
    repeat (600) @(posedge clk);
    link_rd(ADDR_DATA, v);
    chk("dataReg", 0, v);
    chk("dataOut", 0, link.dataOut);
    chk("readyCount", t0, rdyCnt);
    chk("inputClkEn", 1, inClk);
    link_rd(ADDR_PHASE, v);
    chk("phase", 32'h40, v);
    link_wr(ADDR_MODE, 24'h000000);
    t0 = cyc;
    wait_pulse(1200);
    // restart at phase 0x40: a short first period and two more settling wraps, then the output wrap
    chk("readyDelay", 1, (cyc - t0) inside {[945:975]});
    chk("sample", 32'h1000, link.dataOut);
    sw_rd(HADDR_SAMPLE, v);
    chk("hostSample", 32'h1000, v);
    $display("test soft reset done");
    link_wr(ADDR_MODE, 24'h000002);
    link_rd(ADDR_PHASE, v);
    chk("phase", 32'h40, v);
    chk("clkEn", 3'h0, {inClk, coreClk, bias});
    chk("dataOut", 0, link.dataOut);
    link_wr(ADDR_MODE, 24'h000000);
    sw_rd(HADDR_CTRL, v);
    chk("discardBusy", 1, v[4]);
    chk("clkEn", 3'h7, {inClk, coreClk, bias});
    repeat (60) @(posedge clk);
    sw_rd(HADDR_CTRL, v);
    chk("discardBusy", 0, v[4]);
    $display("test shutdown done");
    foreach (bits[i]) begin
      link_wr(ADDR_MODE, 24'h00001A);
      link_rd(ADDR_MODE, v);
      chk("mode", 32'h1A, v);
      chk("fullState", 3'h4, {full, vref, porMon});
      link_wr(ADDR_MODE, 24'h00001A & ~(24'h000001 << bits[i]));
      link_rd(ADDR_PHASE, v);
      chk("monitorState", 3'h3, {full, vref, porMon});
    end
    $display("test full shutdown done");
    link_wr(ADDR_MODE, 24'h000018);
    sw_wr(HADDR_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    sw_wr(HADDR_WRITE, {6'h00, ADDR_PHASE, 24'h000077});
    sw_rd(HADDR_CTRL, v);
    chk("ifaceReady", 0, link.ifaceReady);
    chk("compOut", COMP_RST, comp);
    chk("dataOut", 0, link.dataOut);
    sw_wr(HADDR_CTRL, 32'h0);
    wait_ready();
    link_rd(ADDR_PHASE, v);
    chk("phase", 0, v);
    link_rd(ADDR_MODE, v);
    chk("mode", 0, v);
    chk("compOut", COMP_RUN, comp);
    $display("test hard reset done");
    rstn <= 1'b0;
    strap <= 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait_ready();
    chk("twoWire", 1, link.twoWire);
    link_wr(ADDR_MODE, 24'h00001B);
    link_rd(ADDR_MODE, v);
    chk("mode", 32'h18, v);
    chk("full", 0, full);
    link_wr(ADDR_PHASE, 24'h000040);
    sw_wr(HADDR_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    sw_rd(HADDR_CTRL, v);
    chk("ifaceReady", 1, link.ifaceReady);
    sw_wr(HADDR_CTRL, 32'h0);
    sw_wr(HADDR_CTRL, 32'h2);
    repeat (6) @(posedge clk);
    wait_ready();
    link_rd(ADDR_PHASE, v);
    chk("phase", 0, v);
    $display("test two-wire done");
    conclude();
  end
endmodule
